/* File: core/dsb_bus_if.sv */
// Single-channel DMA system-bus interface, register file and chains
`timescale 1ns/1ps
module dsb_bus_if (
    input wire logic clk_in,
    input wire logic rst_b_in,
    output logic [15:0] addr_out,
    output logic addr_oe_n_out,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_n_out,
    input wire logic bus_grant_in_n_in,
    output logic bus_grant_out_n_out,
    input wire logic bus_request_n_in,
    output logic bus_request_n_out,
    output logic bus_request_oe_n_out,
    input wire logic chip_sel_wait_n_in,
    input wire logic io_strobe_n_in,
    output logic io_strobe_n_out,
    output logic memory_strobe_n_out,
    input wire logic rd_n_in,
    output logic rd_n_out,
    input wire logic wr_n_in,
    output logic wr_n_out,
    output logic strobe_oe_n_out,
    input wire logic irq_chain_in_in,
    output logic irq_chain_out_out,
    output logic irq_n_out,
    output logic irq_oe_n_out,
    input wire logic opcode_fetch_n_in,
    input wire logic ready_in,
    output logic enabled_out
);

    dsb_pkg::dsb_state_t state_ff;
    dsb_pkg::dsb_state_t nxt_state;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] next_rd(input logic [2:0] i, input logic [7:0] m);
        logic [2:0] r;
        logic [2:0] j;
        logic hit;
        r = i;
        hit = 1'b0;
        for (int k = 1; k <= 7; k++)
        begin
            j = 3'((int'(i) + k) % 7);
            if (!hit && !m[j])
            begin
                r = j;
                hit = 1'b1;
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] readback(input dsb_pkg::dsb_state_t s, input logic [2:0] i,
        input logic rdy);
        case (i)
            3'h0: readback = {2'b00, s.eob, s.match, s.pending, 1'b0, rdy, s.xfer};
            3'h1: readback = s.count[7:0];
            3'h2: readback = s.count[15:8];
            3'h3: readback = s.a_addr[7:0];
            3'h4: readback = s.a_addr[15:8];
            3'h5: readback = s.b_addr[7:0];
            3'h6: readback = s.b_addr[15:8];
            default: readback = 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic master;
        logic rdy_act;
        logic wait_hold;
        logic host_wr;
        logic host_rd;
        logic fetch;
        logic ack;
        logic src_a;
        logic src_io;
        logic dst_io;
        logic last_byte;
        logic [7:0] mode;
        logic [7:0] irqc;
        logic [3:0] sel;
        logic [4:0] idx;
        logic [2:0] g;
        logic [1:0] low;
        master = 1'b0;
        rdy_act = 1'b0;
        wait_hold = 1'b0;
        host_wr = 1'b0;
        host_rd = 1'b0;
        fetch = 1'b0;
        ack = 1'b0;
        src_a = 1'b0;
        src_io = 1'b0;
        dst_io = 1'b0;
        last_byte = 1'b0;
        mode = '0;
        irqc = '0;
        sel = '0;
        idx = '0;
        g = '0;
        low = '0;
        nxt_state = state_ff;

        mode = state_ff.ctrl[dsb_pkg::REG_MODE];
        irqc = state_ff.ctrl[dsb_pkg::REG_IRQ];
        master = (state_ff.phase != dsb_pkg::PH_IDLE) && (state_ff.phase != dsb_pkg::PH_REQ);
        rdy_act = (ready_in == mode[dsb_pkg::MODE_RDY_HIGH]);
        wait_hold = mode[dsb_pkg::MODE_WAIT_EN] && !chip_sel_wait_n_in;
        src_a = mode[dsb_pkg::MODE_A_SRC];
        src_io = src_a ? state_ff.ctrl[dsb_pkg::REG_A_TIM][dsb_pkg::TIM_IO]
                       : state_ff.ctrl[dsb_pkg::REG_B_TIM][dsb_pkg::TIM_IO];
        dst_io = src_a ? state_ff.ctrl[dsb_pkg::REG_B_TIM][dsb_pkg::TIM_IO]
                       : state_ff.ctrl[dsb_pkg::REG_A_TIM][dsb_pkg::TIM_IO];

        // Slave decode is blocked while master, so the pins we drive never decode as host access
        host_wr = !master && !chip_sel_wait_n_in && !io_strobe_n_in && !wr_n_in && opcode_fetch_n_in;
        host_rd = !master && !chip_sel_wait_n_in && !io_strobe_n_in && !rd_n_in && opcode_fetch_n_in;
        ack = !master && !opcode_fetch_n_in && !io_strobe_n_in;
        fetch = !master && !opcode_fetch_n_in && !rd_n_in && io_strobe_n_in;
        nxt_state.wr_seen = host_wr;
        nxt_state.rd_seen = host_rd;
        nxt_state.fetch_seen = fetch;

        // ------------------------------------------------------------
        // Register writes
        // ------------------------------------------------------------
        if (host_wr && !state_ff.wr_seen)
        begin
            nxt_state.enabled = 1'b0;
            if (state_ff.ptr != 4'h0)
            begin
                for (int b = 3; b >= 0; b--)
                    if (state_ff.ptr[b])
                        low = 2'(b);
                idx = 5'(dsb_pkg::GRP_FIRST[state_ff.grp] + 5'(low) + 5'h01);
                nxt_state.ctrl[idx] = data_in;
                nxt_state.ptr[low] = 1'b0;
            end
            else if (data_in[2:0] != 3'h7)
            begin
                g = data_in[2:0];
                nxt_state.grp = g;
                nxt_state.ctrl[dsb_pkg::GRP_FIRST[g]] = data_in;
                sel = data_in[dsb_pkg::BASE_PTR_LSB +: 4] & 4'((5'h01 << dsb_pkg::GRP_SIZE[g]) - 5'h01);
                if (g == dsb_pkg::GRP_CMD && data_in[dsb_pkg::BASE_CMD_BIT])
                begin
                    sel = '0;
                    case (data_in[dsb_pkg::BASE_PTR_LSB +: 4])
                        dsb_pkg::CMD_ENABLE: nxt_state.enabled = 1'b1;
                        dsb_pkg::CMD_RESET:
                        begin
                            nxt_state.pending = 1'b0;
                            nxt_state.in_service = 1'b0;
                            nxt_state.xfer = 1'b0;
                            nxt_state.match = 1'b0;
                            nxt_state.eob = 1'b0;
                            nxt_state.have_last = 1'b0;
                        end
                        dsb_pkg::CMD_LOAD:
                        begin
                            nxt_state.a_addr = {state_ff.ctrl[dsb_pkg::REG_A_HI], state_ff.ctrl[dsb_pkg::REG_A_LO]};
                            nxt_state.b_addr = {state_ff.ctrl[dsb_pkg::REG_B_HI], state_ff.ctrl[dsb_pkg::REG_B_LO]};
                            nxt_state.count = '0;
                            nxt_state.have_last = 1'b0;
                        end
                        dsb_pkg::CMD_INIT_READ:
                            nxt_state.rd_idx = next_rd(dsb_pkg::LAST_STATUS, state_ff.ctrl[dsb_pkg::REG_RD_MASK]);
                        dsb_pkg::CMD_CLR_STATUS:
                        begin
                            nxt_state.match = 1'b0;
                            nxt_state.eob = 1'b0;
                            nxt_state.xfer = 1'b0;
                        end
                        default: ;
                    endcase
                end
                nxt_state.ptr = sel;
            end
        end

        // ------------------------------------------------------------
        // Status reads, acknowledge and return watch
        // ------------------------------------------------------------
        if (!master)
        begin
            nxt_state.data_oe_n = 1'b1;
            if (ack && state_ff.pending && irq_chain_in_in)
            begin
                nxt_state.dout = state_ff.ctrl[dsb_pkg::REG_VECTOR];
                nxt_state.data_oe_n = 1'b0;
                nxt_state.pending = 1'b0;
                nxt_state.in_service = 1'b1;
            end
            else if (host_rd)
            begin
                nxt_state.dout = readback(state_ff, state_ff.rd_idx, rdy_act);
                nxt_state.data_oe_n = 1'b0;
            end
            if (state_ff.rd_seen && !host_rd)
                nxt_state.rd_idx = next_rd(state_ff.rd_idx, state_ff.ctrl[dsb_pkg::REG_RD_MASK]);
            if (fetch && !state_ff.fetch_seen)
            begin
                nxt_state.ed_seen = (data_in == dsb_pkg::RET_BYTE0);
                if (state_ff.ed_seen && data_in == dsb_pkg::RET_BYTE1 && irq_chain_in_in)
                    nxt_state.in_service = 1'b0;
            end
            nxt_state.irq_oe_n = !(state_ff.pending && irq_chain_in_in && !state_ff.in_service);
        end
        else
            nxt_state.irq_oe_n = 1'b1;

        // ------------------------------------------------------------
        // Transfer sequencing
        // ------------------------------------------------------------
        case (state_ff.phase)
            dsb_pkg::PH_IDLE:
                if (state_ff.enabled && rdy_act && bus_request_n_in)
                begin
                    nxt_state.breq_oe_n = 1'b0;
                    nxt_state.phase = dsb_pkg::PH_REQ;
                end
            dsb_pkg::PH_REQ:
                if (!bus_grant_in_n_in)
                    nxt_state.phase = dsb_pkg::PH_RD1;
            dsb_pkg::PH_RD1:
            begin
                nxt_state.addr = src_a ? state_ff.a_addr : state_ff.b_addr;
                nxt_state.addr_oe_n = 1'b0;
                nxt_state.strobe_oe_n = 1'b0;
                nxt_state.data_oe_n = 1'b1;
                nxt_state.phase = dsb_pkg::PH_RD2;
            end
            dsb_pkg::PH_RD2:
            begin
                nxt_state.memory_strobe_n_n = src_io;
                nxt_state.io_strobe_n_n = !src_io;
                nxt_state.rd_n = 1'b0;
                if (!state_ff.rd_n && !wait_hold)
                begin
                    nxt_state.data = data_in;
                    // The compare looks at the byte before this one
                    if (state_ff.have_last && (((state_ff.last ^ state_ff.ctrl[dsb_pkg::REG_MATCH])
                        & ~state_ff.ctrl[dsb_pkg::REG_MASK]) == 8'h00))
                    begin
                        nxt_state.match = 1'b1;
                        if (irqc[dsb_pkg::IRQ_MATCH])
                            nxt_state.pending = 1'b1;
                    end
                    nxt_state.last = data_in;
                    nxt_state.have_last = 1'b1;
                    nxt_state.phase = dsb_pkg::PH_RD3;
                end
            end
            dsb_pkg::PH_RD3:
            begin
                nxt_state.memory_strobe_n_n = 1'b1;
                nxt_state.io_strobe_n_n = 1'b1;
                nxt_state.rd_n = 1'b1;
                nxt_state.phase = dsb_pkg::PH_WR1;
            end
            dsb_pkg::PH_WR1:
            begin
                nxt_state.addr = src_a ? state_ff.b_addr : state_ff.a_addr;
                nxt_state.dout = state_ff.data;
                nxt_state.data_oe_n = 1'b0;
                nxt_state.phase = dsb_pkg::PH_WR2;
            end
            dsb_pkg::PH_WR2:
            begin
                nxt_state.memory_strobe_n_n = dst_io;
                nxt_state.io_strobe_n_n = !dst_io;
                nxt_state.wr_n = 1'b0;
                if (!state_ff.wr_n && !wait_hold)
                    nxt_state.phase = dsb_pkg::PH_WR3;
            end
            dsb_pkg::PH_WR3:
            begin
                nxt_state.memory_strobe_n_n = 1'b1;
                nxt_state.io_strobe_n_n = 1'b1;
                nxt_state.wr_n = 1'b1;
                nxt_state.xfer = 1'b1;
                nxt_state.count = state_ff.count + 16'h0001;
                // I/O ports keep a fixed address, memory ports step up
                if (!state_ff.ctrl[dsb_pkg::REG_A_TIM][dsb_pkg::TIM_IO])
                    nxt_state.a_addr = state_ff.a_addr + 16'h0001;
                if (!state_ff.ctrl[dsb_pkg::REG_B_TIM][dsb_pkg::TIM_IO])
                    nxt_state.b_addr = state_ff.b_addr + 16'h0001;
                if (irqc[dsb_pkg::IRQ_PULSE] && nxt_state.count[7:0] == 8'h00)
                    nxt_state.irq_oe_n = 1'b0;
                last_byte = (state_ff.count == {state_ff.ctrl[dsb_pkg::REG_LEN_HI],
                    state_ff.ctrl[dsb_pkg::REG_LEN_LO]});
                if (last_byte)
                begin
                    nxt_state.eob = 1'b1;
                    nxt_state.enabled = 1'b0;
                    if (irqc[dsb_pkg::IRQ_EOB])
                        nxt_state.pending = 1'b1;
                end
                // Bus is only given up at a byte boundary, never taken away mid-operation
                if (last_byte || mode[1:0] == dsb_pkg::XFER_BYTE
                    || (mode[1:0] == dsb_pkg::XFER_BURST && !rdy_act))
                begin
                    nxt_state.phase = dsb_pkg::PH_IDLE;
                    {nxt_state.breq_oe_n, nxt_state.irq_oe_n} = 2'b11;
                    nxt_state.addr_oe_n = 1'b1;
                    nxt_state.strobe_oe_n = 1'b1;
                    nxt_state.data_oe_n = 1'b1;
                end
                else
                    nxt_state.phase = dsb_pkg::PH_NEXT;
            end
            dsb_pkg::PH_NEXT:
            begin
                // Continuous mode pauses here, still master, until ready returns
                nxt_state.data_oe_n = 1'b1;
                if (rdy_act)
                    nxt_state.phase = dsb_pkg::PH_RD1;
            end
            default: nxt_state.phase = dsb_pkg::PH_IDLE;
        endcase

        nxt_state.grant_out_n = bus_grant_in_n_in || (nxt_state.phase != dsb_pkg::PH_IDLE);
        nxt_state.chain_out = irq_chain_in_in && !nxt_state.in_service;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
            state_ff <= dsb_pkg::ST_RESET;
        else
            state_ff <= nxt_state;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign addr_out = state_ff.addr;
    assign addr_oe_n_out = state_ff.addr_oe_n;
    assign data_out = state_ff.dout;
    assign data_oe_n_out = state_ff.data_oe_n;
    assign bus_grant_out_n_out = state_ff.grant_out_n;
    assign bus_request_n_out = state_ff.breq_oe_n;
    assign bus_request_oe_n_out = state_ff.breq_oe_n;
    assign io_strobe_n_out = state_ff.io_strobe_n_n;
    assign memory_strobe_n_out = state_ff.memory_strobe_n_n;
    assign rd_n_out = state_ff.rd_n;
    assign wr_n_out = state_ff.wr_n;
    assign strobe_oe_n_out = state_ff.strobe_oe_n;
    assign irq_chain_out_out = state_ff.chain_out;
    assign irq_n_out = state_ff.irq_oe_n;
    assign irq_oe_n_out = state_ff.irq_oe_n;
    assign enabled_out = state_ff.enabled;

endmodule // dsb_bus_if

/* File: core/dsb_pkg.sv */
// Constants, types and reset state for the DMA system-bus interface
package dsb_pkg;

    // ------------------------------------------------------------
    // Register organisation
    // ------------------------------------------------------------
    localparam int NUM_CTRL = 21;
    localparam logic [6:0][4:0] GRP_FIRST = {5'h12, 5'h11, 5'h0C, 5'h09, 5'h07, 5'h05, 5'h00};
    localparam logic [6:0][2:0] GRP_SIZE = {3'h2, 3'h0, 3'h4, 3'h2, 3'h1, 3'h1, 3'h4};
    localparam logic [4:0] REG_A_LO = 5'h01;
    localparam logic [4:0] REG_A_HI = 5'h02;
    localparam logic [4:0] REG_LEN_LO = 5'h03;
    localparam logic [4:0] REG_LEN_HI = 5'h04;
    localparam logic [4:0] REG_A_TIM = 5'h06;
    localparam logic [4:0] REG_B_TIM = 5'h08;
    localparam logic [4:0] REG_MASK = 5'h0A;
    localparam logic [4:0] REG_MATCH = 5'h0B;
    localparam logic [4:0] REG_B_LO = 5'h0D;
    localparam logic [4:0] REG_B_HI = 5'h0E;
    localparam logic [4:0] REG_IRQ = 5'h0F;
    localparam logic [4:0] REG_VECTOR = 5'h10;
    localparam logic [4:0] REG_RD_MASK = 5'h13;
    localparam logic [4:0] REG_MODE = 5'h14;

    // ------------------------------------------------------------
    // Field positions and codes
    // ------------------------------------------------------------
    localparam int BASE_PTR_LSB = 3;
    localparam int BASE_CMD_BIT = 7;
    localparam logic [2:0] GRP_CMD = 3'h6;
    localparam logic [3:0] CMD_ENABLE = 4'h1;
    localparam logic [3:0] CMD_DISABLE = 4'h2;
    localparam logic [3:0] CMD_RESET = 4'h3;
    localparam logic [3:0] CMD_LOAD = 4'h4;
    localparam logic [3:0] CMD_INIT_READ = 4'h5;
    localparam logic [3:0] CMD_CLR_STATUS = 4'h6;
    localparam logic [1:0] XFER_BYTE = 2'h0;
    localparam logic [1:0] XFER_BURST = 2'h1;
    localparam int MODE_RDY_HIGH = 2;
    localparam int MODE_WAIT_EN = 3;
    localparam int MODE_A_SRC = 4;
    localparam int TIM_IO = 0;
    localparam int IRQ_EOB = 0;
    localparam int IRQ_MATCH = 1;
    localparam int IRQ_PULSE = 2;
    localparam logic [7:0] RET_BYTE0 = 8'hED;
    localparam logic [7:0] RET_BYTE1 = 8'h4D;
    localparam logic [2:0] LAST_STATUS = 3'h6;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [3:0] {PH_IDLE, PH_REQ, PH_RD1, PH_RD2, PH_RD3, PH_WR1, PH_WR2, PH_WR3, PH_NEXT} dsb_phase_t;

    typedef struct packed {
        dsb_phase_t phase;
        logic enabled;
        logic [NUM_CTRL-1:0][7:0] ctrl;
        logic [3:0] ptr;
        logic [2:0] grp;
        logic [15:0] a_addr;
        logic [15:0] b_addr;
        logic [15:0] count;
        logic [7:0] data;
        logic [7:0] last;
        logic have_last;
        logic [2:0] rd_idx;
        logic wr_seen;
        logic rd_seen;
        logic fetch_seen;
        logic ed_seen;
        logic in_service;
        logic pending;
        logic xfer;
        logic match;
        logic eob;
        logic [15:0] addr;
        logic addr_oe_n;
        logic [7:0] dout;
        logic data_oe_n;
        logic memory_strobe_n_n;
        logic io_strobe_n_n;
        logic rd_n;
        logic wr_n;
        logic strobe_oe_n;
        logic breq_oe_n;
        logic grant_out_n;
        logic chain_out;
        logic irq_oe_n;
    } dsb_state_t;

    localparam dsb_state_t ST_RESET = '{phase: PH_IDLE, addr_oe_n: 1'b1, data_oe_n: 1'b1, memory_strobe_n_n: 1'b1,
        io_strobe_n_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, strobe_oe_n: 1'b1, breq_oe_n: 1'b1, grant_out_n: 1'b1,
        irq_oe_n: 1'b1, default: '0};

endpackage

/* File: tb/dsb_bus_if_assertions.sv */
// Port-level checks bound onto the DMA system-bus interface
`timescale 1ns/1ps
module dsb_bus_if_assertions (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic addr_oe_n_out,
    input wire logic [7:0] data_in,
    input wire logic data_oe_n_out,
    input wire logic bus_grant_in_n_in,
    input wire logic bus_grant_out_n_out,
    input wire logic bus_request_n_in,
    input wire logic bus_request_oe_n_out,
    input wire logic chip_sel_wait_n_in,
    input wire logic io_strobe_n_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic rd_n_out,
    input wire logic wr_n_out,
    input wire logic io_strobe_n_out,
    input wire logic memory_strobe_n_out,
    input wire logic strobe_oe_n_out,
    input wire logic irq_chain_in_in,
    input wire logic irq_chain_out_out,
    input wire logic irq_n_out,
    input wire logic opcode_fetch_n_in,
    input wire logic enabled_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    grant_blocked_a: assert property (!bus_request_oe_n_out |-> bus_grant_out_n_out)
        else $error("grant passed on while requesting");
    chain_follow_a: assert property (irq_chain_out_out |-> $past(irq_chain_in_in))
        else $error("chain out high without chain in");
    request_defer_a: assert property ($fell(bus_request_oe_n_out) |-> $past(bus_request_n_in))
        else $error("request raised over another holder");
    addr_master_a: assert property (!addr_oe_n_out |-> !bus_request_oe_n_out && !bus_grant_in_n_in)
        else $error("address driven while not master");
    strobe_master_a: assert property ((!memory_strobe_n_out || !io_strobe_n_out || !rd_n_out || !wr_n_out)
        |-> !strobe_oe_n_out) else $error("strobe active while floated");
    take_bus_a: assert property ($fell(strobe_oe_n_out) |-> !$past(bus_grant_in_n_in) && !bus_request_oe_n_out)
        else $error("strobes driven before grant");
    read_answer_a: assert property ((!chip_sel_wait_n_in && !io_strobe_n_in && !rd_n_in && opcode_fetch_n_in
        && strobe_oe_n_out)[*3] |-> !data_oe_n_out) else $error("status read not answered");
    write_disables_a: assert property ((!chip_sel_wait_n_in && !io_strobe_n_in && !wr_n_in && opcode_fetch_n_in
        && strobe_oe_n_out && data_in != 8'h8E) |-> ##[1:2] !enabled_out) else $error("write left engine on");
    ack_vector_a: assert property (($rose(!opcode_fetch_n_in && !io_strobe_n_in) && irq_chain_in_in
        && !irq_n_out && strobe_oe_n_out) |-> ##[1:2] !data_oe_n_out) else $error("no vector on acknowledge");
endmodule // dsb_bus_if_assertions
bind dsb_bus_if dsb_bus_if_assertions u_chk (.*);

/* File: tb/dsb_host_model.sv */
// Host CPU and memory model on the far side of the bus request chain
`timescale 1ns/1ps
module dsb_host_model (
    input wire logic clk_in,
    input wire logic bus_request_n_in,
    input wire logic [2:0] lat_in,
    input wire logic [15:0] addr_in,
    input wire logic rd_n_in,
    input wire logic strobe_oe_n_in,
    output logic bus_grant_n_out = 1'b1,
    output logic [7:0] data_out
);
    logic [2:0] wait_ff = 3'h0;
    logic [7:0] last_ff = 8'h00;
    always_ff @(posedge clk_in)
    begin
        if (bus_request_n_in)
        begin
            bus_grant_n_out <= 1'b1;
            wait_ff <= lat_in;
        end
        else if (wait_ff != 3'h0)
            wait_ff <= wait_ff - 3'h1;
        else
            bus_grant_n_out <= 1'b0;
        if (!strobe_oe_n_in && !rd_n_in)
            last_ff <= data_out;
    end
    // Released bus shows the inverse of the last byte so a stale sample cannot pass
    assign data_out = (!strobe_oe_n_in && !rd_n_in) ? (addr_in[7:0] ^ 8'h5A) : ~last_ff;
endmodule // dsb_host_model

/* File: tb/test_dsb_bus_if.sv */
// Self-checking bench for the DMA system-bus interface
`timescale 1ns/1ps
module test_dsb_bus_if;
    logic clk_in = 1'b0, rst_b_in = 1'b0, cs_n = 1'b1, h_io = 1'b1, h_rd = 1'b1, h_wr = 1'b1;
    logic h_drv = 1'b0, fetch_n = 1'b1, chain_in = 1'b1, rdy = 1'b1, other_n = 1'b1;
    logic [2:0] lat = 3'h0;
    logic [7:0] h_d = 8'h00, vec, got, m_d, d_out;
    logic [15:0] addr, a0, b0, len;
    logic go_n, req_oe_n, io_o, memory_strobe_n_o, rd_o, wr_o, s_oe_n, chain_out, irq_n, en, d_oe_n, grant_n;
    int errors = 0, n_compared = 0, nw = 0, k;
    logic wr_q = 1'b1;
    wire logic req_w = req_oe_n ? other_n : 1'b0;
    wire logic [7:0] d_w = !d_oe_n ? d_out : (h_drv ? h_d : m_d);
    always #25 clk_in = ~clk_in;
    dsb_bus_if dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_out(addr), .addr_oe_n_out(), .data_in(d_w),
        .data_out(d_out), .data_oe_n_out(d_oe_n), .bus_grant_in_n_in(grant_n), .bus_grant_out_n_out(go_n),
        .bus_request_n_in(req_w), .bus_request_n_out(), .bus_request_oe_n_out(req_oe_n),
        .chip_sel_wait_n_in(cs_n), .io_strobe_n_in(s_oe_n ? h_io : io_o), .io_strobe_n_out(io_o),
        .memory_strobe_n_out(memory_strobe_n_o), .rd_n_in(s_oe_n ? h_rd : rd_o), .rd_n_out(rd_o),
        .wr_n_in(s_oe_n ? h_wr : wr_o), .wr_n_out(wr_o), .strobe_oe_n_out(s_oe_n), .irq_chain_in_in(chain_in),
        .irq_chain_out_out(chain_out), .irq_n_out(irq_n), .irq_oe_n_out(), .opcode_fetch_n_in(fetch_n),
        .ready_in(rdy), .enabled_out(en));
    dsb_host_model host (.clk_in(clk_in), .bus_request_n_in(req_w), .lat_in(lat), .addr_in(addr),
        .rd_n_in(rd_o), .strobe_oe_n_in(s_oe_n), .bus_grant_n_out(grant_n), .data_out(m_d));
    task chk(input logic [15:0] got_v, input logic [15:0] exp_v);
        n_compared++;
        if (got_v !== exp_v)
        begin
            errors++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got_v, exp_v);
        end
    endtask
    task stop_test;
        if (errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task hw(input logic [7:0] b);
        @(negedge clk_in);
        {cs_n, h_io, h_wr, h_drv, h_d} = {4'b0001, b};
        @(negedge clk_in);
        {cs_n, h_io, h_wr, h_drv} = 4'b1110;
        @(negedge clk_in);
    endtask
    task hr(output logic [7:0] b);
        @(negedge clk_in);
        {cs_n, h_io, h_rd} = 3'b000;
        repeat (3) @(negedge clk_in);
        b = d_out;
        chk(d_oe_n, 1'b0);
        {cs_n, h_io, h_rd} = 3'b111;
        repeat (2) @(negedge clk_in);
    endtask
    task fetch(input logic [7:0] b);
        @(negedge clk_in);
        {fetch_n, h_rd, h_drv, h_d} = {3'b001, b};
        @(negedge clk_in);
        {fetch_n, h_rd, h_drv} = 3'b110;
        @(negedge clk_in);
    endtask
    function automatic logic [7:0] exp_rd(input int i);
        logic [15:0] v;
        v = (i < 2) ? len + 16'h1 : ((i < 4) ? a0 + len + 16'h1 : b0 + len + 16'h1);
        return i[0] ? v[15:8] : v[7:0];
    endfunction
    // Write strobe stays low for two edges, so count it once, on the first settled look
    always @(negedge clk_in)
    begin
        if (!s_oe_n && !wr_o && wr_q)
        begin
            chk(addr, b0 + 16'(nw));
            chk({memory_strobe_n_o, io_o, d_out}, {2'b01, a0[7:0] + 8'(nw) ^ 8'h5A});
            nw++;
        end
        wr_q = wr_o;
    end
    initial
    begin
        void'($urandom(44918));
        repeat (5) @(negedge clk_in);
        rst_b_in = 1'b1;
        @(negedge clk_in);
        chk({en, d_oe_n, s_oe_n, req_oe_n}, 4'b0111);
        repeat (6)
        begin
            chain_in = 1'($urandom);
            repeat (2) @(negedge clk_in);
            chk(chain_out, chain_in);
        end
        chain_in = 1'b1;
        // Odd bytes can never look like the enable command byte
        a0 = 16'($urandom) | 16'h0101;
        b0 = 16'($urandom) | 16'h0101;
        len = 16'(1 + $urandom % 4);
        vec = 8'($urandom) | 8'h01;
        lat = 3'($urandom);
        hw(8'h78); hw(a0[7:0]); hw(a0[15:8]); hw(len[7:0]); hw(len[15:8]);
        hw(8'h7C); hw(b0[7:0]); hw(b0[15:8]); hw(8'h01); hw(vec);
        hw(8'h1E); hw(8'h00); hw(8'h16); hw(8'hA6);
        other_n = 1'b0;
        hw(8'h8E);
        repeat (12) @(negedge clk_in);
        chk({req_oe_n, go_n, en}, 3'b101);
        other_n = 1'b1;
        for (k = 0; k < 400 && en !== 1'b0; k++)
            @(negedge clk_in);
        if (en !== 1'b0)
        begin
            errors++;
            stop_test;
        end
        chk(16'(nw), len + 16'h1);
        @(negedge clk_in);
        chk(irq_n, 1'b0);
        hw(8'hAE);
        hr(got);
        // Match bit depends on the random data, so it is left out
        chk(got & 8'hEF, 8'h2B);
        for (k = 0; k < 6; k++)
        begin
            hr(got);
            chk(got, exp_rd(k));
        end
        hw(8'h0E); hw(8'h7D); hw(8'hAE);
        hr(got);
        chk(got, exp_rd(0));
        hr(got);
        chk(got, exp_rd(0));
        @(negedge clk_in);
        {fetch_n, h_io} = 2'b00;
        // Vector stands for one cycle only
        @(negedge clk_in);
        chk({d_oe_n, d_out}, {1'b0, vec});
        {fetch_n, h_io} = 2'b11;
        repeat (3) @(negedge clk_in);
        chk(chain_out, 1'b0);
        fetch(8'hED);
        fetch(8'h4D);
        repeat (2) @(negedge clk_in);
        chk(chain_out, 1'b1);
        stop_test;
    end
endmodule // test_dsb_bus_if
